// ---- logic/ccp_mode_ctrl.sv ----
// capture/compare/pwm mode control, standard and enhanced units
// assumes timers, can receiver and pins are synchronous to clk
//
// Operation
// - one 16-bit value register per unit
// - mode 0000 disables unit, resets its state
// - 0010 toggles pin on match, sets flag
// - 0100 captures each falling edge or message
// - 0101 captures each rising edge or message
// - 0110 captures every fourth rising edge
// - 0111 captures every sixteenth rising edge
// - can select bit 4 picks message trigger
// - 1000 pin low, high on match
// - 1001 pin high, low on match
// - 1010 match only sets the flag
// - 1011 match clears timer, sets flag
// - enhanced special event also starts conversion
// - 11xx pwm, 10-bit duty from two fields
// - non-pwm enhanced: only channel a used
// - output config picks single, half, full bridge
// - pwm codes set pair polarities independently
// - enhanced top bits implemented, standard read zero
`timescale 1ns/1ps
`default_nettype none
module ccp_mode_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_one,
  input wire logic [15:0] timer_three,
  input wire logic [7:0] pwm_timer,
  input wire logic pwm_period_start,
  input wire logic dead_band,
  input wire logic std_capture_in,
  input wire logic enh_capture_in,
  input wire logic can_msg_received,
  output logic std_pin_out,
  output logic std_pin_oe,
  output logic [3:0] enh_pin_out,
  output logic [3:0] enh_pin_oe,
  output logic std_timer_clear,
  output logic enh_timer_clear,
  output logic adc_start,
  output logic irq
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sctl;
    logic [7:0] ectl;
    logic [15:0] sval;
    logic [15:0] eval;
    logic [7:0] can_io;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [3:0] spre;
    logic [3:0] epre;
    logic sin_q;
    logic ein_q;
    logic can_q;
    logic spin;
    logic [3:0] epin;
    logic [7:0] sduty_hi;
    logic [7:0] eduty_hi;
    logic [1:0] sduty_lo;
    logic [1:0] eduty_lo;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic stclr;
    logic etclr;
    logic adc;
    logic irq;
  } ccp_state_t;
  ccp_state_t s_q, s_d;
  logic wr_en, rd_en, ssel, smatch, ematch;
  logic scap_ev, ecap_ev, can_ev, spwm, epwm;
  logic [3:0] smode, emode;
  logic [9:0] scmp, ecmp;
  logic [15:0] stmr, etmr;
  logic [1:0] ev;
  logic s_on, e_on;
  // pin enables, registered apart from the state struct
  logic s_on_q;
  logic [3:0] e_oe_q;

  // --------------------------------------------------------------
  // combinational next state
  // --------------------------------------------------------------
  // apb: one wait state, answer in the second access cycle
  always_comb begin
    s_d = s_q;
    wr_en = psel && penable && pwrite && !s_q.pready;
    rd_en = psel && penable && !pwrite && !s_q.pready;
    smode = s_q.sctl[3:0];
    emode = s_q.ectl[3:0];
    ssel = s_q.can_io[ccp_pkg::CCP_CAN_CAPTURE_SELECT_BIT];
    can_ev = can_msg_received && !s_q.can_q;
    stmr = timer_one;
    etmr = timer_three;
    smatch = (stmr == s_q.sval);
    ematch = (etmr == s_q.eval);
    spwm = (smode[3:2] == 2'b11);
    epwm = (emode[3:2] == 2'b11);
    // edge select per capture mode
    scap_ev = ssel ? can_ev : ((smode == ccp_pkg::CCP_M_CAP_FALL) ?
      (!std_capture_in && s_q.sin_q) : (std_capture_in && !s_q.sin_q));
    ecap_ev = ssel ? can_ev : ((emode == ccp_pkg::CCP_M_CAP_FALL) ?
      (!enh_capture_in && s_q.ein_q) : (enh_capture_in && !s_q.ein_q));
    s_d.sin_q = std_capture_in;
    s_d.ein_q = enh_capture_in;
    s_d.can_q = can_msg_received;
    s_d.stclr = 1'b0;
    s_d.etclr = 1'b0;
    s_d.adc = 1'b0;
    ev = 2'b00;
    s_on = 1'b0;
    e_on = 1'b0;
    // standard unit
    case (smode)
      ccp_pkg::CCP_M_CAP_FALL, ccp_pkg::CCP_M_CAP_RISE: begin
        if (scap_ev) begin
          s_d.sval = stmr;
          ev[0] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_CAP_4, ccp_pkg::CCP_M_CAP_16: begin
        if (scap_ev) begin
          s_d.spre = s_q.spre + 4'h1;
          if (s_q.spre == ((smode == ccp_pkg::CCP_M_CAP_4) ? ccp_pkg::CCP_PRE4_LAST :
              ccp_pkg::CCP_PRE16_LAST)) begin
            s_d.spre = 4'h0;
            s_d.sval = stmr;
            ev[0] = 1'b1;
          end
        end
      end
      ccp_pkg::CCP_M_TOGGLE: begin
        s_on = 1'b1;
        if (smatch) begin
          s_d.spin = !s_q.spin;
          ev[0] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_SET_HI, ccp_pkg::CCP_M_SET_LO: begin
        s_on = 1'b1;
        if (smatch) begin
          s_d.spin = (smode == ccp_pkg::CCP_M_SET_HI);
          ev[0] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_SWINT: ev[0] = smatch;
      ccp_pkg::CCP_M_SPECIAL: begin
        ev[0] = smatch;
        s_d.stclr = smatch;
      end
      default: begin
        if (spwm) begin
          s_on = 1'b1;
          if (pwm_period_start) begin
            s_d.sduty_hi = s_q.sval[7:0];
            s_d.sduty_lo = s_q.sctl[5:4];
          end
          s_d.spin = ({pwm_timer, 2'b00} < scmp);
        end
      end
    endcase
    // enhanced unit
    case (emode)
      ccp_pkg::CCP_M_CAP_FALL, ccp_pkg::CCP_M_CAP_RISE: begin
        if (ecap_ev) begin
          s_d.eval = etmr;
          ev[1] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_CAP_4, ccp_pkg::CCP_M_CAP_16: begin
        if (ecap_ev) begin
          s_d.epre = s_q.epre + 4'h1;
          if (s_q.epre == ((emode == ccp_pkg::CCP_M_CAP_4) ? ccp_pkg::CCP_PRE4_LAST :
              ccp_pkg::CCP_PRE16_LAST)) begin
            s_d.epre = 4'h0;
            s_d.eval = etmr;
            ev[1] = 1'b1;
          end
        end
      end
      ccp_pkg::CCP_M_TOGGLE: begin
        e_on = 1'b1;
        if (ematch) begin
          s_d.epin[0] = !s_q.epin[0];
          ev[1] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_SET_HI, ccp_pkg::CCP_M_SET_LO: begin
        e_on = 1'b1;
        if (ematch) begin
          s_d.epin[0] = (emode == ccp_pkg::CCP_M_SET_HI);
          ev[1] = 1'b1;
        end
      end
      ccp_pkg::CCP_M_SWINT: ev[1] = ematch;
      ccp_pkg::CCP_M_SPECIAL: begin
        ev[1] = ematch;
        s_d.etclr = ematch;
        s_d.adc = ematch;
      end
      default: begin
        if (epwm) begin
          if (pwm_period_start) begin
            s_d.eduty_hi = s_q.eval[7:0];
            s_d.eduty_lo = s_q.ectl[5:4];
          end
          // polarity: emode[1] pair a/c, emode[0] pair b/d
          case (s_q.ectl[7:6])
            ccp_pkg::CCP_OC_SINGLE: s_d.epin = {3'b000, ecmp_on()} ^ {3'b000, emode[1]};
            ccp_pkg::CCP_OC_FWD: s_d.epin = {ecmp_on() ^ emode[0], emode[1],
              emode[0], !emode[1]};
            ccp_pkg::CCP_OC_HALF: s_d.epin = {2'b00,
              (!ecmp_on() && !dead_band) ^ emode[0], (ecmp_on() && !dead_band) ^ emode[1]};
            default: s_d.epin = {!emode[0], emode[1], ecmp_on() ^ emode[0], emode[1]};
          endcase
        end
      end
    endcase
    // mode 0000 holds the unit in its reset state
    if (smode == ccp_pkg::CCP_M_OFF) begin
      s_d.spre = 4'h0;
      s_d.spin = 1'b0;
    end
    if (emode == ccp_pkg::CCP_M_OFF) begin
      s_d.epre = 4'h0;
      s_d.epin = 4'h0;
    end
    // sticky flags, set beats write-one clear
    s_d.stat = (s_q.stat & ~((wr_en && paddr == ccp_pkg::CCP_IRQ_STAT_ADDR) ?
      pwdata[1:0] : 2'b00)) | ev;
    // register writes
    if (wr_en) begin
      case (paddr)
        ccp_pkg::CCP_STD_CTRL_ADDR: begin
          s_d.sctl = pwdata[7:0] & ccp_pkg::CCP_STD_CTRL_MASK;
          s_d.spre = 4'h0;
          if (pwdata[3:0] == ccp_pkg::CCP_M_SET_HI) s_d.spin = 1'b0;
          if (pwdata[3:0] == ccp_pkg::CCP_M_SET_LO) s_d.spin = 1'b1;
        end
        ccp_pkg::CCP_ENH_CTRL_ADDR: begin
          s_d.ectl = pwdata[7:0];
          s_d.epre = 4'h0;
          if (pwdata[3:0] == ccp_pkg::CCP_M_SET_HI) s_d.epin[0] = 1'b0;
          if (pwdata[3:0] == ccp_pkg::CCP_M_SET_LO) s_d.epin[0] = 1'b1;
        end
        ccp_pkg::CCP_STD_VAL_ADDR: s_d.sval = pwdata[15:0];
        ccp_pkg::CCP_ENH_VAL_ADDR: s_d.eval = pwdata[15:0];
        ccp_pkg::CCP_CAN_IO_ADDR: s_d.can_io = pwdata[7:0];
        ccp_pkg::CCP_IRQ_MASK_ADDR: s_d.mask = pwdata[1:0];
        default: ;
      endcase
    end
    // read mux
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (rd_en) begin
      case (paddr)
        ccp_pkg::CCP_STD_CTRL_ADDR: s_d.prdata = {24'h000000, s_q.sctl};
        ccp_pkg::CCP_ENH_CTRL_ADDR: s_d.prdata = {24'h000000, s_q.ectl};
        ccp_pkg::CCP_STD_VAL_ADDR: s_d.prdata = {16'h0000, s_q.sval};
        ccp_pkg::CCP_ENH_VAL_ADDR: s_d.prdata = {16'h0000, s_q.eval};
        ccp_pkg::CCP_CAN_IO_ADDR: s_d.prdata = {24'h000000, s_q.can_io};
        ccp_pkg::CCP_IRQ_STAT_ADDR: s_d.prdata = {30'h00000000, s_q.stat};
        ccp_pkg::CCP_IRQ_MASK_ADDR: s_d.prdata = {30'h00000000, s_q.mask};
        ccp_pkg::CCP_PIN_ADDR: s_d.prdata = {27'h0000000, s_q.epin, s_q.spin};
        default: begin
          s_d.prdata = 32'h00000000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end else if (wr_en) begin
      s_d.pslverr = !(paddr[7:5] == 3'b000 && paddr[1:0] == 2'b00 &&
        paddr != ccp_pkg::CCP_PIN_ADDR && paddr != ccp_pkg::CCP_IRQ_STAT_ADDR ||
        paddr == ccp_pkg::CCP_IRQ_STAT_ADDR);
    end
    s_d.irq = |(s_d.stat & s_q.mask);
  end

  // duty compare values, 10 bits
  assign scmp = {s_q.sduty_hi, s_q.sduty_lo};
  assign ecmp = {s_q.eduty_hi, s_q.eduty_lo};

  // enhanced pwm raw active level
  function automatic logic ecmp_on();
    ecmp_on = ({pwm_timer, 2'b00} < ecmp);
  endfunction

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops; enables decoded from registered mode
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign std_pin_out = s_q.spin;
  assign std_pin_oe = s_on_q;
  assign enh_pin_out = s_q.epin;
  assign enh_pin_oe = e_oe_q;
  assign std_timer_clear = s_q.stclr;
  assign enh_timer_clear = s_q.etclr;
  assign adc_start = s_q.adc;
  assign irq = s_q.irq;

  // pin enables registered separately; unused channels go to port use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_on_q <= 1'b0;
      e_oe_q <= 4'h0;
    end else begin
      s_on_q <= s_on;
      if (!epwm) begin
        e_oe_q <= {3'b000, e_on};
      end else begin
        case (s_q.ectl[7:6])
          ccp_pkg::CCP_OC_SINGLE: e_oe_q <= 4'b0001;
          ccp_pkg::CCP_OC_HALF: e_oe_q <= 4'b0011;
          default: e_oe_q <= 4'b1111;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/ccp_pkg.sv ----
// package for the capture/compare/pwm mode control block
// assumes an apb slave with 32-bit data and word-aligned registers
package ccp_pkg;
  // register byte addresses
  localparam logic [7:0] CCP_STD_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CCP_ENH_CTRL_ADDR = 8'h04;
  localparam logic [7:0] CCP_STD_VAL_ADDR = 8'h08;
  localparam logic [7:0] CCP_ENH_VAL_ADDR = 8'h0C;
  localparam logic [7:0] CCP_CAN_IO_ADDR = 8'h10;
  localparam logic [7:0] CCP_IRQ_STAT_ADDR = 8'h14;
  localparam logic [7:0] CCP_IRQ_MASK_ADDR = 8'h18;
  localparam logic [7:0] CCP_PIN_ADDR = 8'h1C;
  // reset values
  localparam logic [7:0] CCP_CTRL_RST = 8'h00;
  localparam logic [15:0] CCP_VAL_RST = 16'h0000;
  // field positions
  localparam int CCP_CAN_CAPTURE_SELECT_BIT = 4;
  localparam logic [7:0] CCP_STD_CTRL_MASK = 8'h3F;
  // mode codes
  localparam logic [3:0] CCP_M_OFF = 4'h0;
  localparam logic [3:0] CCP_M_TOGGLE = 4'h2;
  localparam logic [3:0] CCP_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCP_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCP_M_CAP_4 = 4'h6;
  localparam logic [3:0] CCP_M_CAP_16 = 4'h7;
  localparam logic [3:0] CCP_M_SET_HI = 4'h8;
  localparam logic [3:0] CCP_M_SET_LO = 4'h9;
  localparam logic [3:0] CCP_M_SWINT = 4'hA;
  localparam logic [3:0] CCP_M_SPECIAL = 4'hB;
  // output configuration
  localparam logic [1:0] CCP_OC_SINGLE = 2'h0;
  localparam logic [1:0] CCP_OC_FWD = 2'h1;
  localparam logic [1:0] CCP_OC_HALF = 2'h2;
  localparam logic [1:0] CCP_OC_REV = 2'h3;
  // prescale terminal counts
  localparam logic [3:0] CCP_PRE4_LAST = 4'h3;
  localparam logic [3:0] CCP_PRE16_LAST = 4'hF;
endpackage

// ---- verification/ccp_partner.sv ----
// far-side model: the two 16-bit timers and the pwm timebase
// assumes the bench gates counting with run
`timescale 1ns/1ps
`default_nettype none
module ccp_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic std_timer_clear,
  input wire logic enh_timer_clear,
  output logic [15:0] timer_one,
  output logic [15:0] timer_three,
  output logic [7:0] pwm_timer,
  output logic pwm_period_start
);
  // ----------------------------------------
  // timers hold while stopped, clear on event
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_one <= 16'h0000;
      timer_three <= 16'h0000;
      pwm_timer <= 8'h00;
      pwm_period_start <= 1'b0;
    end else if (run) begin
      timer_one <= std_timer_clear ? 16'h0000 : timer_one + 16'h0001;
      timer_three <= enh_timer_clear ? 16'h0000 : timer_three + 16'h0001;
      pwm_timer <= pwm_timer + 8'h01;
      pwm_period_start <= (pwm_timer == 8'hFE);
    end
  end
endmodule
`default_nettype wire

// ---- verification/ccp_mode_ctrl_properties.sv ----
// port assertions for the mode control block
// assumes one clock domain, bound to every ccp_mode_ctrl
`timescale 1ns/1ps
`default_nettype none
module ccp_mode_ctrl_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic std_timer_clear,
  input wire logic adc_start,
  input wire logic enh_timer_clear,
  input wire logic [3:0] enh_pin_oe
);
  // ----------------------------------------
  // bus and event checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_one_wait:
    assert property ($rose(penable) && psel |=> pready) else $error("late answer");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("long ready");
  a_unmapped_err:
    assert property (pready && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
  a_mapped_ok:
    assert property (pready && paddr < 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped refused");
  a_ro_write:
    assert property (pready && pwrite && paddr == 8'h1C |-> pslverr) else $error("ro write");
  a_upper_zero:
    assert property (pready && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper bits");
  a_clear_pulse:
    assert property (std_timer_clear |=> !std_timer_clear) else $error("long clear");
  a_adc_clear:
    assert property (adc_start |-> enh_timer_clear) else $error("adc without clear");
  a_bridge_oe:
    assert property (enh_pin_oe[3] || enh_pin_oe[2] |-> enh_pin_oe == 4'hF) else $error("bridge");
  a_chan_a_oe:
    assert property (enh_pin_oe[1] |-> enh_pin_oe[0]) else $error("channel a");
endmodule
bind ccp_mode_ctrl ccp_mode_ctrl_chk u_ccp_mode_ctrl_chk (.*);
`default_nettype wire

// ---- verification/tb_ccp_mode_ctrl.sv ----
// self-checking bench for the mode control block
// assumes the timer model in ccp_partner
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
`define WAITFOR(c) begin wn = 0; while (!(c) && wn < 300) begin @(posedge clk); wn++; end end
module tb_ccp_mode_ctrl;
  // ----------------------------------------
  // signals, models, clock
  // ----------------------------------------
  localparam logic [7:0] A_SC = ccp_pkg::CCP_STD_CTRL_ADDR;
  localparam logic [7:0] A_EC = ccp_pkg::CCP_ENH_CTRL_ADDR;
  localparam logic [7:0] A_SV = ccp_pkg::CCP_STD_VAL_ADDR;
  localparam logic [7:0] A_EV = ccp_pkg::CCP_ENH_VAL_ADDR;
  localparam logic [7:0] A_ST = ccp_pkg::CCP_IRQ_STAT_ADDR;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b1;
  logic dead_band = 1'b0, std_capture_in = 1'b0, enh_capture_in = 1'b0, can_msg_received = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pwm_period_start, std_pin_out, std_pin_oe, irq;
  logic std_timer_clear, enh_timer_clear, adc_start;
  logic [15:0] timer_one, timer_three;
  logic [7:0] pwm_timer;
  logic [3:0] enh_pin_out, enh_pin_oe;
  int fails = 0, comparisons = 0, wn, cyc = 0;
  ccp_mode_ctrl u_ccp_mode_ctrl (.*);
  ccp_partner u_ccp_partner (.*);
  always #5 clk = ~clk;
  // bench time limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] x, input logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 40);
    if (!w) `CHK(prdata, x)
    `CHK(pslverr, e)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, x, 1'b0);
  endtask
  // one input edge pair: rise, then fall
  task automatic pulse_in(input bit can);
    if (can) can_msg_received <= 1'b1;
    else std_capture_in <= 1'b1;
    repeat (6) @(posedge clk);
    can_msg_received <= 1'b0;
    std_capture_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(A_SC, 32'h0);
    wr(A_SC, 32'hF0);
    rd(A_SC, 32'h30);
    wr(A_EC, 32'hF0);
    rd(A_EC, 32'hF0);
    xfer(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, ccp_pkg::CCP_PIN_ADDR, 32'h1, 32'h0, 1'b1);
    wr(A_EC, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_cap();
    logic [3:0] md [3] = '{4'h5, 4'h6, 4'h7};
    int cnt [3] = '{1, 4, 16};
    wr(ccp_pkg::CCP_IRQ_MASK_ADDR, 32'h3);
    run <= 1'b0;
    foreach (md[i]) begin
      wr(A_SC, {28'h0, md[i]});
      for (int k = 0; k < cnt[i]; k++) begin
        `CHK(irq, 1'b0)
        pulse_in(1'b0);
      end
      `CHK(irq, 1'b1)
      rd(A_SV, {16'h0, timer_one});
      wr(A_ST, 32'h1);
      rd(A_ST, 32'h0);
    end
    wr(A_SC, 32'h4);
    std_capture_in <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(irq, 1'b0)
    std_capture_in <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(ccp_pkg::CCP_CAN_IO_ADDR, 32'h10);
    wr(A_SC, 32'h5);
    wr(A_ST, 32'h1);
    pulse_in(1'b0);
    `CHK(irq, 1'b0)
    pulse_in(1'b1);
    `CHK(irq, 1'b1)
    wr(ccp_pkg::CCP_CAN_IO_ADDR, 32'h0);
    wr(A_ST, 32'h1);
    $display("t_cap done");
  endtask
  task automatic t_cmp();
    logic [3:0] md [2] = '{4'h8, 4'h9};
    run <= 1'b1;
    foreach (md[i]) begin
      wr(A_SC, 32'h0);
      `CHK(std_pin_oe, 1'b0)
      wr(A_SV, {16'h0, timer_one + 16'h0040});
      wr(A_SC, {28'h0, md[i]});
      `CHK(std_pin_out, md[i][0])
      `WAITFOR(std_pin_out !== md[i][0])
      `CHK(std_pin_out, ~md[i][0])
      rd(A_ST, 32'h1);
      wr(A_ST, 32'h1);
    end
    wr(A_SV, {16'h0, timer_one + 16'h0040});
    wr(A_SC, 32'hA);
    `CHK(std_pin_oe, 1'b0)
    `WAITFOR(irq === 1'b1)
    `CHK(irq, 1'b1)
    wr(A_EV, {16'h0, timer_three + 16'h0040});
    wr(A_EC, 32'hB);
    `WAITFOR(enh_timer_clear === 1'b1)
    `CHK(adc_start, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(timer_three < 16'h0004, 1'b1)
    wr(A_EC, 32'h0);
    wr(A_SC, 32'h0);
    wr(A_ST, 32'h3);
    $display("t_cmp done");
  endtask
  task automatic t_pwm();
    logic [3:0] oe [4] = '{4'h1, 4'hF, 4'h3, 4'hF};
    for (int c = 0; c < 4; c++) begin
      wr(A_EC, {24'h0, c[1:0], 6'h0C});
      `CHK(enh_pin_oe, oe[c])
    end
    wr(A_EV, 32'h0);
    wr(A_EC, 32'h0F);
    `WAITFOR(pwm_period_start === 1'b1)
    repeat (3) @(posedge clk);
    `CHK(enh_pin_out[0], 1'b1)
    wr(A_EC, 32'h0C);
    `CHK(enh_pin_out[0], 1'b0)
    wr(A_EV, 32'hFFFF);
    wr(A_EC, 32'h3C);
    `WAITFOR(pwm_period_start === 1'b1)
    repeat (3) @(posedge clk);
    `CHK(enh_pin_out[0], 1'b1)
    wr(A_EC, 32'h0);
    `CHK(enh_pin_oe, 4'h0)
    $display("t_pwm done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cap();
    t_cmp();
    t_pwm();
    print_verdict();
  end
endmodule
`default_nettype wire
